/* hdl/rwic_ctrl.sv */
// Reset, wake-up, interrupt and timebase/watchdog prescaler controller with APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
module rwic_ctrl #(
	parameter int WDT_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic ext_reset_n_in,
	input wire logic por_in,
	input wire logic svd_reset_in,
	input wire logic svd_select_in,
	input wire logic rc_mode_in,
	input wire logic [2:0] sub_div_in,
	input wire logic halt_instr_in,
	input wire logic halt_deep_in,
	input wire logic watchdog_clear_instr_in,
	input wire logic irq_enable_instr_in,
	input wire logic irq_disable_instr_in,
	input wire logic sw_irq_instr_in,
	input wire logic [3:0] port_seven_in,
	input wire logic [7:0] port_nine_in,
	input wire logic cnt1_ovf_in,
	input wire logic cnt2_ovf_in,
	output logic cpu_reset_out,
	output logic fetch_redirect_out,
	output logic [rwic_pkg::PC_W-1:0] fetch_addr_out,
	output logic instr_clk_en_out,
	output logic osc_run_out,
	output logic halted_out,
	output logic [7:0] port_direction_out,
	output logic [7:0] lcd_control_out
);
	// Watchdog widths the counter can serve; read-back shows only its low 8 bits
	if (WDT_W < 2 || WDT_W > 24) begin : g_wdt_w_check
		$error("WDT_W out of range");
	end

	logic [7:0] control_option_reg, timebase_counter, prescaler_reg;
	logic [7:0] irq_mask_reg, wake_control_reg, status_reg, register_select_reg;
	logic [rwic_pkg::NUM_IRQ-1:0] irq_flag_reg, irq_flag_next, irq_set;
	logic [WDT_W-1:0] watchdog_timer;
	logic [rwic_pkg::DIV_W-1:0] div_reg, div_mask;
	logic [rwic_pkg::SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, pin_prev_reg;
	logic [1:0] ovf_prev_reg;
	logic clock_select_reg, tb_msb_prev_reg, gie_reg, rst_req_reg, pwr_rst_reg;
	rwic_pkg::rwic_state_e state_reg;
	logic sys_rst, apb_wr, apb_setup, presc_tick, tb_tick, tb_fall, wdt_en, wdt_timeout;
	logic wr_tb, wr_flag, port_nine_change, wake_any, irq_go, sw_go;
	logic [7:0] presc_mask, rd_data;
	logic rd_hit;

	assign sys_rst = rst_in || rst_req_reg;
	assign apb_setup = psel_in && !penable_in;
	assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;
	assign wr_tb = apb_wr && paddr_in == rwic_pkg::OFS_TIMEBASE;
	assign wr_flag = apb_wr && paddr_in == rwic_pkg::OFS_IRQ_FLAG;
	assign wdt_en = wake_control_reg[rwic_pkg::WAKE_WDT_EN_BIT];

	// Pin inputs: three stages, change accepted once stages two and three agree
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sync1_reg <= rwic_pkg::SYNC_RST;
			sync2_reg <= rwic_pkg::SYNC_RST;
			sync3_reg <= rwic_pkg::SYNC_RST;
			pin_reg <= rwic_pkg::SYNC_RST;
			pin_prev_reg <= rwic_pkg::SYNC_RST;
		end else begin
			sync1_reg <= {port_nine_in, port_seven_in, ext_reset_n_in, svd_reset_in, por_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg <= (~(sync2_reg ^ sync3_reg) & sync2_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);
			pin_prev_reg <= pin_reg;
		end
	end

	// Instruction clock enable; no RC mode means full rate
	always_comb begin
		div_mask = '0;
		if (rc_mode_in) begin
			if (clock_select_reg) begin
				div_mask = rwic_pkg::DIV_W'((4 << sub_div_in) - 1);
			end else begin
				div_mask = rwic_pkg::DIV_W'(1);
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			div_reg <= '0;
			instr_clk_en_out <= 1'b0;
		end else begin
			div_reg <= div_reg + 1'b1;
			instr_clk_en_out <= (div_reg & div_mask) == div_mask;
		end
	end

	// Prescaler tap; watchdog side gets one octave less than timebase side
	always_comb begin
		if (control_option_reg[rwic_pkg::COR_PAB_BIT]) begin
			presc_mask = 8'((8'h01 << control_option_reg[2:0]) - 1);
		end else begin
			presc_mask = 8'((8'h02 << control_option_reg[2:0]) - 1);
		end
	end
	assign presc_tick = instr_clk_en_out && (prescaler_reg & presc_mask) == presc_mask;

	// Shared prescaler, one owner at a time
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			prescaler_reg <= rwic_pkg::RST_ZERO8;
		end else if (wr_tb) begin
			prescaler_reg <= rwic_pkg::RST_ZERO8;
		end else if (control_option_reg[rwic_pkg::COR_PAB_BIT] &&
				(watchdog_clear_instr_in || halt_instr_in)) begin
			prescaler_reg <= rwic_pkg::RST_ZERO8;
		end else if (instr_clk_en_out && (control_option_reg[rwic_pkg::COR_PAB_BIT] ||
				state_reg != rwic_pkg::ST_SLEEP)) begin
			prescaler_reg <= prescaler_reg + 8'h01;
		end
	end

	// Timebase counter; frozen in sleep because the oscillator stops
	assign tb_tick = control_option_reg[rwic_pkg::COR_PAB_BIT] ? instr_clk_en_out : presc_tick;
	assign tb_fall = tb_msb_prev_reg && !timebase_counter[7];
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			timebase_counter <= rwic_pkg::RST_ZERO8;
			tb_msb_prev_reg <= 1'b0;
		end else begin
			tb_msb_prev_reg <= timebase_counter[7];
			if (wr_tb) begin
				timebase_counter <= rwic_pkg::RST_ZERO8;
			end else if (tb_tick && state_reg != rwic_pkg::ST_SLEEP) begin
				timebase_counter <= timebase_counter + 8'h01;
			end
		end
	end

	// Watchdog; runs in all states so it can wake or reset from halt
	assign wdt_timeout = wdt_en && &watchdog_timer &&
		(control_option_reg[rwic_pkg::COR_PAB_BIT] ? presc_tick : instr_clk_en_out);
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			watchdog_timer <= '0;
		end else if (watchdog_clear_instr_in || halt_instr_in || !wdt_en) begin
			watchdog_timer <= '0;
		end else if (control_option_reg[rwic_pkg::COR_PAB_BIT] ? presc_tick : instr_clk_en_out) begin
			watchdog_timer <= watchdog_timer + 1'b1;
		end
	end

	// Reset request from pin, power source and watchdog or sleep wake
	assign port_nine_change = |(pin_reg[14:7] ^ pin_prev_reg[14:7]);
	assign wake_any = wdt_timeout ||
		(port_nine_change && wake_control_reg[rwic_pkg::WAKE_PORT_NINE_BIT]);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rst_req_reg <= 1'b0;
			pwr_rst_reg <= 1'b0;
			cpu_reset_out <= 1'b1;
		end else begin
			pwr_rst_reg <= svd_select_in ? pin_reg[1] : pin_reg[0];
			rst_req_reg <= !pin_reg[2] || (svd_select_in ? pin_reg[1] : pin_reg[0]) ||
				(wdt_timeout && state_reg == rwic_pkg::ST_RUN) ||
				(state_reg == rwic_pkg::ST_SLEEP && wake_any);
			cpu_reset_out <= rst_req_reg;
		end
	end

	// Halt state machine
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			state_reg <= rwic_pkg::ST_RUN;
			osc_run_out <= 1'b1;
			halted_out <= 1'b0;
		end else begin
			case (state_reg)
				rwic_pkg::ST_RUN: begin
					if (halt_instr_in) begin
						state_reg <= halt_deep_in ? rwic_pkg::ST_SLEEP : rwic_pkg::ST_IDLE;
						osc_run_out <= !halt_deep_in;
						halted_out <= 1'b1;
					end
				end
				rwic_pkg::ST_IDLE: begin
					if (wake_any || tb_fall) begin
						state_reg <= rwic_pkg::ST_RUN;
						halted_out <= 1'b0;
					end
				end
				rwic_pkg::ST_SLEEP: begin
					osc_run_out <= 1'b0; // Wake leaves through the reset request
				end
				default: begin
					state_reg <= rwic_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Falling-edge detection of interrupt sources; set beats a software clear
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			ovf_prev_reg <= 2'h0;
		end else begin
			ovf_prev_reg <= {cnt2_ovf_in, cnt1_ovf_in};
		end
	end

	always_comb begin
		irq_set = '0;
		irq_set[rwic_pkg::IRQ_TB] = tb_fall;
		irq_set[rwic_pkg::IRQ_EXT_A] = pin_prev_reg[3] && !pin_reg[3];
		irq_set[rwic_pkg::IRQ_EXT_B] = pin_prev_reg[4] && !pin_reg[4];
		irq_set[rwic_pkg::IRQ_EXT_CD] = (pin_prev_reg[5] && !pin_reg[5]) ||
			(pin_prev_reg[6] && !pin_reg[6]);
		irq_set[rwic_pkg::IRQ_CNT1] = ovf_prev_reg[0] && !cnt1_ovf_in;
		irq_set[rwic_pkg::IRQ_CNT2] = ovf_prev_reg[1] && !cnt2_ovf_in;
		irq_set = irq_set & (irq_mask_reg[5:0] | 6'h01);
		irq_flag_next = wr_flag ? pwdata_in[5:0] : irq_flag_reg;
		irq_flag_next = irq_flag_next | irq_set;
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			irq_flag_reg <= '0;
		end else begin
			irq_flag_reg <= irq_flag_next;
		end
	end

	// Vectoring; reset forces a redirect to the reset vector, so a same-cycle event is dropped
	assign irq_go = gie_reg && state_reg == rwic_pkg::ST_RUN && |(irq_flag_reg & irq_mask_reg[5:0]);
	assign sw_go = sw_irq_instr_in && state_reg == rwic_pkg::ST_RUN;
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			gie_reg <= 1'b0;
			fetch_redirect_out <= 1'b1;
			fetch_addr_out <= rwic_pkg::VEC_RESET;
		end else begin
			fetch_redirect_out <= sw_go || irq_go;
			if (sw_go) begin
				fetch_addr_out <= rwic_pkg::VEC_SOFT;
			end else if (irq_go) begin
				fetch_addr_out <= rwic_pkg::VEC_HARD;
			end
			if (irq_go && !sw_go) begin
				gie_reg <= 1'b0; // Blocks re-entry until the service routine re-enables
			end else if (irq_enable_instr_in) begin
				gie_reg <= 1'b1;
			end else if (irq_disable_instr_in) begin
				gie_reg <= 1'b0;
			end
		end
	end

	// Software registers set to their reset values by every reset
	always_ff @(posedge mclk_in) begin
		if (sys_rst) begin
			control_option_reg <= rwic_pkg::RST_CONTROL_OPTION;
			wake_control_reg <= rwic_pkg::RST_ZERO8;
			irq_mask_reg <= rwic_pkg::RST_ZERO8;
			lcd_control_out <= rwic_pkg::RST_LCD_CONTROL;
			port_direction_out <= rwic_pkg::RST_PORT_DIRECTION;
			clock_select_reg <= 1'b0;
		end else if (apb_wr) begin
			case (paddr_in)
				rwic_pkg::OFS_CONTROL_OPTION: control_option_reg <= pwdata_in[7:0];
				rwic_pkg::OFS_WAKE_CONTROL: wake_control_reg <= pwdata_in[7:0];
				rwic_pkg::OFS_IRQ_MASK: irq_mask_reg <= {2'h0, pwdata_in[5:0]};
				rwic_pkg::OFS_LCD_CONTROL: lcd_control_out <= pwdata_in[7:0];
				rwic_pkg::OFS_PORT_DIRECTION: port_direction_out <= pwdata_in[7:0];
				rwic_pkg::OFS_CLOCK_SELECT: clock_select_reg <= pwdata_in[rwic_pkg::CLK_SUB_SELECT_BIT];
				default: begin
				end
			endcase
		end
	end

	// Status and bank select survive non-power resets; only power-up clears upper bits
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			status_reg <= rwic_pkg::RST_ZERO8;
			register_select_reg <= rwic_pkg::RST_ZERO8;
		end else if (pwr_rst_reg) begin
			status_reg <= status_reg & rwic_pkg::STATUS_PWR_KEEP;
			register_select_reg <= register_select_reg & rwic_pkg::RSEL_PWR_KEEP;
		end else if (apb_wr && paddr_in == rwic_pkg::OFS_STATUS) begin
			status_reg <= pwdata_in[7:0];
		end else if (apb_wr && paddr_in == rwic_pkg::OFS_REGISTER_SELECT) begin
			register_select_reg <= pwdata_in[7:0];
		end
	end

	// Read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_data = rwic_pkg::RST_ZERO8;
		case (paddr_in)
			rwic_pkg::OFS_CONTROL_OPTION: rd_data = control_option_reg;
			rwic_pkg::OFS_TIMEBASE: rd_data = timebase_counter;
			rwic_pkg::OFS_IRQ_FLAG: rd_data = {2'h0, irq_flag_reg};
			rwic_pkg::OFS_IRQ_MASK: rd_data = irq_mask_reg;
			rwic_pkg::OFS_WAKE_CONTROL: rd_data = wake_control_reg;
			rwic_pkg::OFS_STATUS: rd_data = status_reg;
			rwic_pkg::OFS_REGISTER_SELECT: rd_data = register_select_reg;
			rwic_pkg::OFS_LCD_CONTROL: rd_data = lcd_control_out;
			rwic_pkg::OFS_PORT_DIRECTION: rd_data = port_direction_out;
			rwic_pkg::OFS_CLOCK_SELECT: rd_data = {7'h00, clock_select_reg};
			rwic_pkg::OFS_WATCHDOG: rd_data = 8'(watchdog_timer);
			rwic_pkg::OFS_CORE_STATE: rd_data = {4'h0, gie_reg, state_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// APB slave: no wait states, data captured in setup so access sees it stable
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= '0;
		end else begin
			pready_out <= apb_setup;
			if (apb_setup) begin
				pslverr_out <= !rd_hit;
				prdata_out <= {24'h000000, rd_data};
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence idle_tb_seq;
		state_reg == rwic_pkg::ST_IDLE && tb_fall && !rst_req_reg && !wr_flag;
	endsequence
	sequence resumed_seq;
		state_reg == rwic_pkg::ST_RUN && irq_flag_reg[rwic_pkg::IRQ_TB];
	endsequence

	tb_write_clear_a: assert property (wr_tb && !rst_req_reg |=>
		timebase_counter == 8'h00 && prescaler_reg == 8'h00) else $error("timebase write no clear");
	wdt_presc_clear_a: assert property (watchdog_clear_instr_in &&
		control_option_reg[rwic_pkg::COR_PAB_BIT] |=> prescaler_reg == 8'h00)
		else $error("prescaler kept on watchdog clear");
	halt_presc_keep_a: assert property (halt_instr_in && state_reg == rwic_pkg::ST_RUN &&
		!control_option_reg[rwic_pkg::COR_PAB_BIT] && !sys_rst && !wr_tb
		|=> prescaler_reg == 8'($past(prescaler_reg) + $past(instr_clk_en_out)))
		else $error("prescaler changed on halt");
	reset_vector_a: assert property (rst_req_reg |=>
		fetch_redirect_out && fetch_addr_out == rwic_pkg::VEC_RESET && osc_run_out)
		else $error("reset did not vector to zero");
	reset_defaults_a: assert property (rst_req_reg |=>
		control_option_reg == rwic_pkg::RST_CONTROL_OPTION && !wdt_en &&
		irq_mask_reg == 8'h00 && watchdog_timer == '0) else $error("reset defaults wrong");
	wdt_reset_a: assert property (wdt_timeout && state_reg == rwic_pkg::ST_RUN
		|=> rst_req_reg ##1 cpu_reset_out) else $error("watchdog timeout did not reset");
	hw_vector_a: assert property (irq_go && !sw_go && !sys_rst |=>
		fetch_redirect_out && fetch_addr_out == rwic_pkg::VEC_HARD && !gie_reg)
		else $error("hardware vector wrong");
	sw_vector_a: assert property (sw_go && !sys_rst |=>
		fetch_redirect_out && fetch_addr_out == rwic_pkg::VEC_SOFT) else $error("soft vector wrong");
	idle_resume_a: assert property (idle_tb_seq |=> resumed_seq)
		else $error("idle timebase wake wrong");
	sleep_wake_a: assert property (state_reg == rwic_pkg::ST_SLEEP && wake_any
		|=> rst_req_reg) else $error("sleep wake did not reset");
	flag_hold_a: assert property (!wr_flag && !sys_rst |=>
		(irq_flag_reg & $past(irq_flag_reg)) == $past(irq_flag_reg)) else $error("flag lost");
endmodule // rwic_ctrl

/* hdl/rwic_pkg.sv */
// Constants, register map and state codes for the reset, wake and interrupt controller
// Notes on behaviour
// - One 8-bit prescaler serves timebase or watchdog, chosen by option bit 3.
// - Writing the timebase counter clears the timebase counter and the prescaler.
// - With prescaler on watchdog, watchdog-clear or halt instruction clears the prescaler.
// - With prescaler on timebase, the halt instruction leaves the prescaler untouched.
// - RC mode: instruction clock is half oscillation, or half sub frequency if selected.
// - Reset from pin, power-on or voltage detect, or enabled watchdog timeout while running.
// - A code option picks voltage-detect reset; otherwise power-on reset is used.
// - Any reset keeps oscillator running, clears program counter, fetches from 000H.
// - Power-up only clears status upper three bits and register-select upper two bits.
// - Any reset clears watchdog and prescaler, disables watchdog, sets option bits all ones.
// - Reset sets port direction all ones, LCD control 00110000, clears interrupt mask.
// - Halted device wakes on timebase timeout (idle only), watchdog, or port nine change.
// - Idle wake resumes after the halt instruction; sleep wake performs a reset.
// - A timebase timeout wake sets interrupt flag bit 0.
// - Counter overflows set flags on falling edges when masked in; the timebase flag sets unmasked.
// - Enable and disable instructions gate interrupts; pending enabled interrupt vectors 008H.
// - Flags stay set until software clears them; software clears before re-enabling.
// - External interrupts come from port seven bits 0 to 3, gated by mask bits.
// - Software interrupt instruction vectors to 001H, apart from the hardware vector.
// - Timebase timeout vectors 008H when running; from idle it resumes first, then vectors.
// - Mask bits 0..5: timebase, ext a, ext b, ext c or d, counter one, counter two.
package rwic_pkg;
	localparam int PC_W = 11;
	localparam int DIV_W = 9;
	localparam int SYNC_W = 15;
	localparam int NUM_IRQ = 6;

	// Register byte offsets on the APB
	localparam logic [7:0] OFS_CONTROL_OPTION = 8'h00;
	localparam logic [7:0] OFS_TIMEBASE = 8'h04;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_WAKE_CONTROL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_REGISTER_SELECT = 8'h18;
	localparam logic [7:0] OFS_LCD_CONTROL = 8'h1c;
	localparam logic [7:0] OFS_PORT_DIRECTION = 8'h20;
	localparam logic [7:0] OFS_CLOCK_SELECT = 8'h24;
	localparam logic [7:0] OFS_WATCHDOG = 8'h28;
	localparam logic [7:0] OFS_CORE_STATE = 8'h2c;

	// Reset values
	localparam logic [7:0] RST_CONTROL_OPTION = 8'hff;
	localparam logic [7:0] RST_LCD_CONTROL = 8'h30;
	localparam logic [7:0] RST_PORT_DIRECTION = 8'hff;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	localparam logic [7:0] STATUS_PWR_KEEP = 8'h1f;
	localparam logic [7:0] RSEL_PWR_KEEP = 8'h3f;
	localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0004;

	// Field positions
	localparam int COR_PAB_BIT = 3;
	localparam int COR_RATIO_LSB = 0;
	localparam int WAKE_WDT_EN_BIT = 7;
	localparam int WAKE_PORT_NINE_BIT = 6;
	localparam int CLK_SUB_SELECT_BIT = 0;
	localparam int IRQ_TB = 0;
	localparam int IRQ_EXT_A = 1;
	localparam int IRQ_EXT_B = 2;
	localparam int IRQ_EXT_CD = 3;
	localparam int IRQ_CNT1 = 4;
	localparam int IRQ_CNT2 = 5;

	// Fetch vectors
	localparam logic [PC_W-1:0] VEC_RESET = 11'h000;
	localparam logic [PC_W-1:0] VEC_SOFT = 11'h001;
	localparam logic [PC_W-1:0] VEC_HARD = 11'h008;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_IDLE = 3'b010,
		ST_SLEEP = 3'b100
	} rwic_state_e;
endpackage // rwic_pkg

/* sim/rwic_pin_model.sv */
// Behavioural model of the reset pin and the interrupt and wake-up pins
module rwic_pin_model (
	input wire logic mclk_in,
	output logic ext_reset_n_out,
	output logic [3:0] port_seven_out,
	output logic [7:0] port_nine_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Reset and port seven pins idle high, as with the port seven pull-ups enabled
	initial begin
		ext_reset_n_out = 1'b1;
		port_seven_out = 4'hf;
		port_nine_out = 8'h5a;
	end

	// Active-low reset pin held for a number of cycles
	task automatic hold_reset(input int cycles);
		@(posedge mclk_in);
		ext_reset_n_out <= 1'b0;
		repeat (cycles) @(posedge mclk_in);
		ext_reset_n_out <= 1'b1;
	endtask

	// Falling edge on one external interrupt pin, long enough for the synchroniser
	task automatic fall_seven(input int idx);
		@(posedge mclk_in);
		port_seven_out[idx] <= 1'b0;
		repeat (6) @(posedge mclk_in);
		port_seven_out[idx] <= 1'b1;
	endtask

	// Any change on port nine is a wake-up source
	task automatic change_nine();
		@(posedge mclk_in);
		port_nine_out <= ~port_nine_out;
	endtask
endmodule // rwic_pin_model

/* sim/tb_top.sv */
// Self-checking testbench for the reset, wake and interrupt controller
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} rwic_note_s;

	logic mclk_in, rst_in, psel, penable, pwrite, halt_deep, cnt1_ovf, cnt2_ovf, in_rst;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_out, lfsr;
	logic [4:0] strb;
	logic pready_out, pslverr_out, cpu_reset_out, fetch_redirect_out, instr_clk_en_out;
	logic osc_run_out, halted_out, ext_reset_n, por, svd_rst, svd_sel, rc_mode;
	logic [rwic_pkg::PC_W-1:0] fetch_addr_out;
	logic [7:0] port_direction_out, lcd_control_out, port_nine;
	logic [3:0] port_seven;
	int num_errors, comparisons, cycles;
	rwic_note_s q_apb[$];
	logic [rwic_pkg::PC_W-1:0] q_vec[$];

	rwic_ctrl #(.WDT_W(3)) rwic_ctrl_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .ext_reset_n_in(ext_reset_n), .por_in(por),
		.svd_reset_in(svd_rst), .svd_select_in(svd_sel), .rc_mode_in(rc_mode),
		.sub_div_in(3'h0), .halt_instr_in(strb[0]), .halt_deep_in(halt_deep),
		.watchdog_clear_instr_in(strb[1]), .irq_enable_instr_in(strb[2]),
		.irq_disable_instr_in(strb[4]), .sw_irq_instr_in(strb[3]),
		.port_seven_in(port_seven), .port_nine_in(port_nine),
		.cnt1_ovf_in(cnt1_ovf), .cnt2_ovf_in(cnt2_ovf), .cpu_reset_out(cpu_reset_out),
		.fetch_redirect_out(fetch_redirect_out), .fetch_addr_out(fetch_addr_out),
		.instr_clk_en_out(instr_clk_en_out), .osc_run_out(osc_run_out),
		.halted_out(halted_out), .port_direction_out(port_direction_out),
		.lcd_control_out(lcd_control_out));

	rwic_pin_model rwic_pin_model_inst (.mclk_in(mclk_in), .ext_reset_n_out(ext_reset_n),
		.port_seven_out(port_seven), .port_nine_out(port_nine));

	// 125 MHz clock
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	// Single comparison point; case inequality so unknowns never match
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// Bench-side pseudo-random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	// One APB transfer; the expected answer is queued for the monitor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic [31:0] msk, input logic err);
		q_apb.push_back('{exp: exp, msk: msk, err: err});
		@(posedge mclk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready_out !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle instruction strobe
	task automatic strobe(input int idx);
		@(posedge mclk_in);
		strb[idx] <= 1'b1;
		@(posedge mclk_in);
		strb[idx] <= 1'b0;
	endtask

	// Enables counted over 16 cycles, once the setting has settled
	task automatic count_en(input int exp);
		int k;
		k = 0;
		repeat (2) @(posedge mclk_in);
		repeat (16) begin
			@(posedge mclk_in);
			k += instr_clk_en_out;
		end
		check("instr_clk_en_out", k, exp);
	endtask

	// Bounded wait on halted_out (sel 0) or cpu_reset_out (sel 1)
	task automatic wait_for(input int sel, input logic v);
		int n;
		n = 0;
		while (((sel == 0) ? halted_out : cpu_reset_out) !== v && n < 64) begin
			@(posedge mclk_in);
			n++;
		end
		check("wait bound", {31'h0, n < 64}, 32'h1);
	endtask

	// Monitor: APB completions and fetch redirections against queued notes
	always @(posedge mclk_in) begin
		rwic_note_s nt;
		if (psel && penable && pready_out === 1'b1) begin
			nt = q_apb.pop_front();
			check("prdata", prdata_out & nt.msk, nt.exp);
			check("pslverr", {31'h0, pslverr_out}, {31'h0, nt.err});
		end
		if (fetch_redirect_out === 1'b1 && cpu_reset_out === 1'b0 && !in_rst) begin
			if (q_vec.size() == 0) check("redirect", 32'h1, 32'h0);
			else check("fetch_addr", {21'h0, fetch_addr_out}, {21'h0, q_vec.pop_front()});
		end
	end

	// Hang guard
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Register reset values after power-up
	task automatic reset_values();
		apb(1'b0, rwic_pkg::OFS_CONTROL_OPTION, 0, 32'hff, 32'hffffffff, 1'b0);
		apb(1'b0, rwic_pkg::OFS_WATCHDOG, 0, 32'h0, 32'hffffffff, 1'b0);
		apb(1'b0, rwic_pkg::OFS_LCD_CONTROL, 0, 32'h30, 32'hffffffff, 1'b0);
		apb(1'b0, rwic_pkg::OFS_PORT_DIRECTION, 0, 32'hff, 32'hffffffff, 1'b0);
		apb(1'b0, rwic_pkg::OFS_IRQ_MASK, 0, 32'h0, 32'hffffffff, 1'b0);
		check("port_direction_out", {24'h0, port_direction_out}, 32'hff);
		check("lcd_control_out", {24'h0, lcd_control_out}, 32'h30);
	endtask

	// Main sequence
	initial begin
		rst_in = 1'b1;
		{psel, penable, pwrite, halt_deep, in_rst, por, svd_rst, svd_sel, rc_mode} = '0;
		{cnt1_ovf, cnt2_ovf} = 2'b11;
		paddr = 8'h00;
		pwdata = 32'h0;
		strb = 5'h00;
		lfsr = 32'd70818;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		reset_values();
		apb(1'b0, 8'hfc, 0, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'hf0, 32'h5a, 32'h0, 32'h0, 1'b1);
		// Mask register read-back with random contents, gie still off
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			apb(1'b1, rwic_pkg::OFS_IRQ_MASK, lfsr, 32'h0, 32'h0, 1'b0);
			apb(1'b0, rwic_pkg::OFS_IRQ_MASK, 0, lfsr & 32'h3f, 32'hffffffff, 1'b0);
		end
		// Prescaler to timebase at slowest ratio, then clear the counter
		apb(1'b1, rwic_pkg::OFS_CONTROL_OPTION, 32'h07, 32'h0, 32'h0, 1'b0);
		apb(1'b1, rwic_pkg::OFS_TIMEBASE, 32'ha5, 32'h0, 32'h0, 1'b0);
		apb(1'b0, rwic_pkg::OFS_TIMEBASE, 0, 32'h0, 32'hffffffff, 1'b0);
		// Counter overflow vectors to the hardware address once enabled
		apb(1'b1, rwic_pkg::OFS_IRQ_MASK, 32'h32, 32'h0, 32'h0, 1'b0);
		apb(1'b1, rwic_pkg::OFS_IRQ_FLAG, 32'h0, 32'h0, 32'h0, 1'b0);
		q_vec.push_back(rwic_pkg::VEC_HARD);
		strobe(2);
		@(posedge mclk_in) cnt1_ovf <= 1'b0;
		repeat (6) @(posedge mclk_in);
		cnt1_ovf <= 1'b1;
		cnt2_ovf <= 1'b0;
		fork rwic_pin_model_inst.fall_seven(0); join
		cnt2_ovf <= 1'b1;
		repeat (6) @(posedge mclk_in);
		apb(1'b0, rwic_pkg::OFS_IRQ_FLAG, 0, 32'h32, 32'h3e, 1'b0);
		apb(1'b1, rwic_pkg::OFS_IRQ_FLAG, 32'h0, 32'h0, 32'h0, 1'b0);
		apb(1'b0, rwic_pkg::OFS_IRQ_FLAG, 0, 32'h0, 32'h3e, 1'b0);
		// Disabled interrupts leave the flag pending until re-enabled
		strobe(2);
		strobe(4);
		@(posedge mclk_in) cnt1_ovf <= 1'b0;
		repeat (8) @(posedge mclk_in);
		cnt1_ovf <= 1'b1;
		q_vec.push_back(rwic_pkg::VEC_HARD);
		strobe(2);
		repeat (4) @(posedge mclk_in);
		apb(1'b1, rwic_pkg::OFS_IRQ_FLAG, 32'h0, 32'h0, 32'h0, 1'b0);
		q_vec.push_back(rwic_pkg::VEC_SOFT);
		strobe(3);
		repeat (4) @(posedge mclk_in);
		check("vector queue", q_vec.size(), 32'h0);
		// Full rate, half rate in RC mode, quarter with sub clock selected
		count_en(16);
		rc_mode <= 1'b1;
		count_en(8);
		apb(1'b1, rwic_pkg::OFS_CLOCK_SELECT, 32'h1, 32'h0, 32'h0, 1'b0);
		count_en(4);
		rc_mode <= 1'b0;
		// Idle halt woken by port nine, no reset
		apb(1'b1, rwic_pkg::OFS_WAKE_CONTROL, 32'h40, 32'h0, 32'h0, 1'b0);
		strobe(0);
		@(posedge mclk_in);
		check("halted_out", {31'h0, halted_out}, 32'h1);
		rwic_pin_model_inst.change_nine();
		wait_for(0, 1'b0);
		check("cpu_reset_out", {31'h0, cpu_reset_out}, 32'h0);
		apb(1'b0, rwic_pkg::OFS_CONTROL_OPTION, 0, 32'h07, 32'hffffffff, 1'b0);
		// Sleep halt woken by port nine performs a reset
		in_rst = 1'b1;
		halt_deep <= 1'b1;
		strobe(0);
		repeat (2) @(posedge mclk_in);
		check("osc_run_out", {31'h0, osc_run_out}, 32'h0);
		rwic_pin_model_inst.change_nine();
		wait_for(1, 1'b1);
		halt_deep <= 1'b0;
		wait_for(1, 1'b0);
		repeat (2) @(posedge mclk_in);
		apb(1'b0, rwic_pkg::OFS_CONTROL_OPTION, 0, 32'hff, 32'hffffffff, 1'b0);
		// Only the selected power source resets, and it masks status
		apb(1'b1, rwic_pkg::OFS_STATUS, 32'hff, 32'h0, 32'h0, 1'b0);
		svd_sel <= 1'b1;
		por <= 1'b1;
		repeat (8) @(posedge mclk_in);
		check("cpu_reset_out", {31'h0, cpu_reset_out}, 32'h0);
		por <= 1'b0;
		svd_rst <= 1'b1;
		wait_for(1, 1'b1);
		svd_rst <= 1'b0;
		wait_for(1, 1'b0);
		apb(1'b0, rwic_pkg::OFS_STATUS, 0, 32'h1f, 32'hffffffff, 1'b0);
		// Enabled watchdog times out in run, resets and is left disabled
		apb(1'b1, rwic_pkg::OFS_CONTROL_OPTION, 32'h08, 32'h0, 32'h0, 1'b0);
		strobe(1);
		apb(1'b1, rwic_pkg::OFS_WAKE_CONTROL, 32'h80, 32'h0, 32'h0, 1'b0);
		wait_for(1, 1'b1);
		wait_for(1, 1'b0);
		apb(1'b0, rwic_pkg::OFS_WAKE_CONTROL, 0, 32'h0, 32'hffffffff, 1'b0);
		// Reset pin: vector to 000 with oscillator running
		fork rwic_pin_model_inst.hold_reset(8); join_none
		wait_for(1, 1'b1);
		check("fetch_addr_out", {21'h0, fetch_addr_out}, {21'h0, rwic_pkg::VEC_RESET});
		check("osc_run_out", {31'h0, osc_run_out}, 32'h1);
		wait_for(1, 1'b0);
		repeat (4) @(posedge mclk_in);
		reset_values();
		in_rst = 1'b0;
		repeat (4) @(posedge mclk_in);
		check("apb queue", q_apb.size(), 32'h0);
		final_report();
	end
endmodule // tb_top
